// [logic/lvip_pkg.sv]
package lvip_pkg;

    // Command byte codes, sent with the command/data select low.
    localparam logic [7:0] CMD_VOL_MODE = 8'h81;
    localparam logic [7:0] CMD_IND_OFF  = 8'hac;
    localparam logic [7:0] CMD_IND_ON   = 8'had;
    localparam logic [7:0] CMD_ALL_NORM = 8'ha4;
    localparam logic [7:0] CMD_ALL_ON   = 8'ha5;
    localparam logic [7:0] CMD_DISP_OFF = 8'hae;
    localparam logic [7:0] CMD_DISP_ON  = 8'haf;
    localparam logic [7:0] CMD_RESET    = 8'he2;
    localparam logic [7:0] CMD_NOP      = 8'he3;

    // Volume register width and values.
    localparam int         VOL_W      = 6;
    localparam logic [5:0] VOL_RST    = 6'h20;
    localparam logic [5:0] VOL_UNUSED = 6'h20;

    // Indicator register encodings.
    localparam logic [1:0] IND_OFF    = 2'h0;
    localparam logic [1:0] IND_SLOW   = 2'h1;
    localparam logic [1:0] IND_FAST   = 2'h2;
    localparam logic [1:0] IND_STEADY = 2'h3;

    // Timing: clock rate, blink periods and the frame half period.
    localparam int CLK_MHZ        = 100;
    localparam int BLINK_SLOW_MS  = 1000;
    localparam int BLINK_FAST_MS  = 500;
    localparam int BLINK_SLOW_HALF_CYC = BLINK_SLOW_MS * 1000 * CLK_MHZ / 2;
    localparam int BLINK_FAST_HALF_CYC = BLINK_FAST_MS * 1000 * CLK_MHZ / 2;
    localparam int FRAME_HALF_CYC = 1000;
    localparam int BLINK_CNT_W    = 26;
    localparam int FRAME_CNT_W    = 10;

    // Host register map (byte addresses) and field positions.
    localparam logic [7:0] ADDR_CMD  = 8'h00;
    localparam logic [7:0] ADDR_VOL  = 8'h04;
    localparam logic [7:0] ADDR_IND  = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam int CMD_A0_BIT     = 8;
    localparam int IND_ON_BIT     = 2;
    localparam int CTRL_HRST_BIT  = 0;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_BLANK_BIT = 1;

    // Sequencer states of the two ends.
    typedef enum logic [1:0] {ARM_NONE, ARM_VOL, ARM_IND} lvip_arm_type;
    typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} lvip_tx_type;

    // True when a command byte with the given code is on the bus.
    function automatic logic lvip_is_cmd(input logic       stb,
                                         input logic [7:0] dat,
                                         input logic [7:0] code);
        return stb && (dat == code);
    endfunction

endpackage

// [logic/lvip_if.sv]
interface lvip_if;
    logic       wr_stb;
    logic       cmd_data_select;
    logic [7:0] data;
    logic       hard_reset_n;
    logic       display_blank_n;

    modport host (output wr_stb, output cmd_data_select, output data,
                  output hard_reset_n, input display_blank_n);
    modport dev  (input wr_stb, input cmd_data_select, input data,
                  input hard_reset_n, output display_blank_n);
endinterface

// [logic/lvip_ind_drive.sv]
module lvip_ind_drive
    import lvip_pkg::*;
#(
    parameter int SLOW_HALF_CYC = lvip_pkg::BLINK_SLOW_HALF_CYC,
    parameter int FAST_HALF_CYC = lvip_pkg::BLINK_FAST_HALF_CYC
) (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // Control.
    input  wire logic       i_run,
    input  wire logic       i_on,
    input  wire logic [1:0] i_mode,
    // Static drive pins.
    output logic            o_frame,
    output logic            o_seg
);
    logic [FRAME_CNT_W-1:0] frame_cnt_r;
    logic [BLINK_CNT_W-1:0] blink_cnt_r;
    logic                   frame_r;
    logic                   blink_r;
    logic                   seg_r;
    logic                   frame_nxt;
    logic                   lit;
    logic [BLINK_CNT_W-1:0] blink_last;

    // Segment is driven against the frame when lit, with it when dark.
    always_comb begin
        frame_nxt = (frame_cnt_r == FRAME_CNT_W'(FRAME_HALF_CYC - 1))
                    ? ~frame_r : frame_r;
        blink_last = (i_mode == IND_FAST) ? BLINK_CNT_W'(FAST_HALF_CYC - 1)
                                          : BLINK_CNT_W'(SLOW_HALF_CYC - 1);
        lit = i_on && ((i_mode == IND_STEADY) ||
                       (((i_mode == IND_SLOW) || (i_mode == IND_FAST))
                        && blink_r));
    end

    // Frame divider; with the oscillator stopped both pins sit high.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !i_run) begin
            frame_cnt_r <= '0;
            frame_r     <= 1'b1;
            seg_r       <= 1'b1;
        end else begin
            frame_cnt_r <= (frame_nxt != frame_r) ? '0 : frame_cnt_r + 1'b1;
            frame_r     <= frame_nxt;
            seg_r       <= lit ? ~frame_nxt : frame_nxt;
        end
    end

    // Blink phase; starts lit and toggles every half period.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !i_run || !i_on) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b1;
        end else if (blink_cnt_r >= blink_last) begin
            blink_cnt_r <= '0;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    assign o_frame = frame_r;
    assign o_seg   = seg_r;
endmodule

// [logic/lvip_dev.sv]
// How it works
// - Host sends volume mode then value, paired.
// - Byte 0x81 arms volume value acceptance.
// - Armed: next command byte is the value.
// - Value low six bits load volume.
// - Loading the value disarms volume mode.
// - Host loads 100000 when volume unused.
// - Indicator byte bit0: off, or on+second byte.
// - After on, next byte sets indicator register.
// - Two low bits pick off/slow/fast/steady.
// - Other commands except reset leave indicator untouched.
// - Indicator driven by frame and segment pins.
// - All-on with display off enters power save.
// - Indicator off sleeps, on stands by.
// - Power save keeps modes, serves memory access.
// - Sleep stops oscillator, supply, drives high.
// - Standby stops supply, keeps indicator running.
// - Reset command in standby moves to sleep.
// - Blanking output low during power save.
// - Oscillator runs straight after power up.
// - Reset command restores volume and indicator.
module lvip_dev
    import lvip_pkg::*;
#(
    parameter int BLINK_SLOW_HALF = lvip_pkg::BLINK_SLOW_HALF_CYC,
    parameter int BLINK_FAST_HALF = lvip_pkg::BLINK_FAST_HALF_CYC
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Command bus from the host.
    lvip_if.dev              link,
    // Analog control levels.
    output logic [VOL_W-1:0] o_lcd_drive_level,
    output logic             o_osc_run,
    output logic             o_supply_run,
    output logic             o_duty_run,
    // Static indicator pins.
    output logic             o_frame_polarity_out,
    output logic             o_indicator_segment_out,
    // Mode status.
    output logic             o_disp_on,
    output logic             o_all_on,
    output logic             o_sleep,
    output logic             o_standby,
    output logic [1:0]       o_ind_mode,
    output logic             o_ind_on,
    // Display memory write port.
    output logic             o_ram_wr,
    output logic [7:0]       o_ram_wdata
);
    logic             hrst_meta_r;
    logic             hrst_sync_r;
    logic             rstn_int;
    logic             cmd_stb;
    logic             idle_stb;
    logic [7:0]       dat;
    lvip_arm_type     arm_r;
    logic [VOL_W-1:0] vol_r;
    logic             ind_on_r;
    logic [1:0]       ind_mode_r;
    logic             disp_on_r;
    logic             all_on_r;
    logic             save_r;
    logic             sleep_r;
    logic             ram_wr_r;
    logic [7:0]       ram_wdata_r;
    logic             standby;

    // The reset pin comes from outside and is synchronised first.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            hrst_meta_r <= 1'b0;
            hrst_sync_r <= 1'b0;
        end else begin
            hrst_meta_r <= link.hard_reset_n;
            hrst_sync_r <= hrst_meta_r;
        end
    end

    // Internal reset and command strobes.
    assign rstn_int = i_rstn && hrst_sync_r;
    assign cmd_stb  = link.wr_stb && !link.cmd_data_select;
    assign idle_stb = cmd_stb && (arm_r == ARM_NONE);
    assign dat      = link.data;
    assign standby  = save_r && !sleep_r;

    // Double-byte sequencer; any command byte while armed is the value.
    always_ff @(posedge i_clk) begin
        if (!rstn_int) begin
            arm_r <= ARM_NONE;
        end else if (cmd_stb) begin
            case (arm_r)
                ARM_NONE: begin
                    if (dat == CMD_VOL_MODE) begin
                        arm_r <= ARM_VOL;
                    end else if (dat == CMD_IND_ON) begin
                        arm_r <= ARM_IND;
                    end
                end
                ARM_VOL: arm_r <= ARM_NONE;
                ARM_IND: arm_r <= ARM_NONE;
                default: arm_r <= ARM_NONE;
            endcase
        end
    end

    // Volume register.
    always_ff @(posedge i_clk) begin
        if (!rstn_int) begin
            vol_r <= VOL_RST;
        end else if (cmd_stb && (arm_r == ARM_VOL)) begin
            vol_r <= dat[VOL_W-1:0];
        end else if (lvip_is_cmd(idle_stb, dat, CMD_RESET)) begin
            vol_r <= VOL_RST;
        end
    end

    // Indicator state; only the indicator bytes and reset reach it.
    always_ff @(posedge i_clk) begin
        if (!rstn_int) begin
            ind_on_r   <= 1'b0;
            ind_mode_r <= IND_OFF;
        end else if (cmd_stb && (arm_r == ARM_IND)) begin
            ind_mode_r <= dat[1:0];
        end else if (lvip_is_cmd(idle_stb, dat, CMD_IND_ON)) begin
            ind_on_r <= 1'b1;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_IND_OFF)) begin
            ind_on_r <= 1'b0;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_RESET)) begin
            ind_on_r   <= 1'b0;
            ind_mode_r <= IND_OFF;
        end
    end

    // Display on/off and all-points flags; kept through power save.
    always_ff @(posedge i_clk) begin
        if (!rstn_int) begin
            disp_on_r <= 1'b0;
            all_on_r  <= 1'b0;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_DISP_ON)) begin
            disp_on_r <= 1'b1;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_DISP_OFF)) begin
            disp_on_r <= 1'b0;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_ALL_ON) && disp_on_r) begin
            all_on_r <= 1'b1;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_ALL_NORM)) begin
            all_on_r <= 1'b0;
        end
    end

    // Power saver entry, variant choice, reset demotion and exit.
    always_ff @(posedge i_clk) begin
        if (!rstn_int) begin
            save_r  <= 1'b0;
            sleep_r <= 1'b0;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_ALL_ON) && !disp_on_r)
        begin
            save_r  <= 1'b1;
            sleep_r <= !ind_on_r;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_ALL_NORM)) begin
            save_r  <= 1'b0;
            sleep_r <= 1'b0;
        end else if (lvip_is_cmd(idle_stb, dat, CMD_RESET) && standby) begin
            sleep_r <= 1'b1;
        end
    end

    // Display memory writes pass in every mode, power save included.
    always_ff @(posedge i_clk) begin
        if (!rstn_int) begin
            ram_wr_r    <= 1'b0;
            ram_wdata_r <= 8'h00;
        end else begin
            ram_wr_r <= link.wr_stb && link.cmd_data_select;
            if (link.wr_stb && link.cmd_data_select) begin
                ram_wdata_r <= dat;
            end
        end
    end

    // Static indicator waveform; it runs while the oscillator runs.
    lvip_ind_drive #(
        .SLOW_HALF_CYC (BLINK_SLOW_HALF),
        .FAST_HALF_CYC (BLINK_FAST_HALF)
    ) u_ind (
        .i_clk   (i_clk),
        .i_rstn  (rstn_int),
        .i_run   (!(save_r && sleep_r)),
        .i_on    (ind_on_r),
        .i_mode  (ind_mode_r),
        .o_frame (o_frame_polarity_out),
        .o_seg   (o_indicator_segment_out)
    );

    // Power controls; with no pair armed the NOP byte matches no branch and changes nothing.
    assign o_osc_run    = !(save_r && sleep_r);
    assign o_supply_run = !save_r;
    assign o_duty_run   = !save_r;
    assign link.display_blank_n = !save_r;

    // Status outputs from flip-flops; o_sleep and o_standby are decoded from save_r and sleep_r.
    assign o_lcd_drive_level = vol_r;
    assign o_disp_on   = disp_on_r;
    assign o_all_on    = all_on_r;
    assign o_sleep     = save_r && sleep_r;
    assign o_standby   = standby;
    assign o_ind_mode  = ind_mode_r;
    assign o_ind_on    = ind_on_r;
    assign o_ram_wr    = ram_wr_r;
    assign o_ram_wdata = ram_wdata_r;
endmodule

// [logic/lvip_host.sv]
module lvip_host
    import lvip_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Command bus to the device.
    lvip_if.host             link
);
    lvip_tx_type      tx_r;
    logic [8:0]       first_r;
    logic [7:0]       second_r;
    logic             pair_r;
    logic [VOL_W-1:0] vol_r;
    logic [2:0]       ind_r;
    logic             hrst_r;
    logic [31:0]      rdata_r;
    logic             err_r;
    logic             stb_r;
    logic             a0_r;
    logic [7:0]       data_r;
    logic             blank_meta_r;
    logic             blank_sync_r;
    logic             busy;
    logic             send_addr;
    logic             wr_ok;
    logic             mapped;

    // Decode; writes that start a send stall while a send is going on.
    assign busy      = (tx_r != TX_IDLE);
    assign send_addr = (i_paddr == ADDR_CMD) || (i_paddr == ADDR_VOL) ||
                       (i_paddr == ADDR_IND);
    assign mapped    = send_addr || (i_paddr == ADDR_CTRL) ||
                       (i_paddr == ADDR_STAT);
    assign o_pready  = !(i_pwrite && send_addr && busy);
    assign wr_ok     = i_psel && i_penable && i_pwrite && o_pready && mapped;

    // Read data and error are captured in the setup cycle.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end else if (i_psel && !i_penable) begin
            err_r   <= !mapped;
            rdata_r <= 32'h0000_0000;
            case (i_paddr)
                ADDR_VOL:  rdata_r[VOL_W-1:0] <= vol_r;
                ADDR_IND:  rdata_r[2:0] <= ind_r;
                ADDR_CTRL: rdata_r[CTRL_HRST_BIT] <= hrst_r;
                ADDR_STAT: begin
                    rdata_r[STAT_BUSY_BIT]  <= busy;
                    rdata_r[STAT_BLANK_BIT] <= blank_sync_r;
                end
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign o_prdata  = rdata_r;
    assign o_pslverr = err_r && i_penable;

    // Shadow registers; volume starts at the recommended unused level.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            vol_r  <= VOL_UNUSED;
            ind_r  <= 3'h0;
            hrst_r <= 1'b0;
        end else if (wr_ok) begin
            if (i_paddr == ADDR_VOL) begin
                vol_r <= i_pwdata[VOL_W-1:0];
            end
            if (i_paddr == ADDR_IND) begin
                ind_r <= i_pwdata[2:0];
            end
            if (i_paddr == ADDR_CTRL) begin
                hrst_r <= i_pwdata[CTRL_HRST_BIT];
            end
        end
    end

    // Send sequencer; a pair goes out on two consecutive cycles.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tx_r     <= TX_IDLE;
            first_r  <= 9'h000;
            second_r <= 8'h00;
            pair_r   <= 1'b0;
        end else begin
            case (tx_r)
                TX_IDLE: begin
                    if (wr_ok && send_addr) begin
                        tx_r <= TX_FIRST;
                        case (i_paddr)
                            ADDR_VOL: begin
                                first_r  <= {1'b0, CMD_VOL_MODE};
                                second_r <= {2'b00, i_pwdata[VOL_W-1:0]};
                                pair_r   <= 1'b1;
                            end
                            ADDR_IND: begin
                                pair_r   <= i_pwdata[IND_ON_BIT];
                                first_r  <= i_pwdata[IND_ON_BIT]
                                            ? {1'b0, CMD_IND_ON}
                                            : {1'b0, CMD_IND_OFF};
                                second_r <= {6'h00, i_pwdata[1:0]};
                            end
                            default: begin
                                first_r <= i_pwdata[CMD_A0_BIT:0];
                                pair_r  <= 1'b0;
                            end
                        endcase
                    end
                end
                TX_FIRST:  tx_r <= pair_r ? TX_SECOND : TX_IDLE;
                TX_SECOND: tx_r <= TX_IDLE;
                default:   tx_r <= TX_IDLE;
            endcase
        end
    end

    // Bus pins, registered; the blanking pin is synchronised.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            stb_r        <= 1'b0;
            a0_r         <= 1'b0;
            data_r       <= 8'h00;
            blank_meta_r <= 1'b1;
            blank_sync_r <= 1'b1;
        end else begin
            stb_r        <= (tx_r == TX_FIRST) || (tx_r == TX_SECOND);
            a0_r         <= (tx_r == TX_FIRST) && first_r[CMD_A0_BIT];
            data_r       <= (tx_r == TX_SECOND) ? second_r : first_r[7:0];
            blank_meta_r <= link.display_blank_n;
            blank_sync_r <= blank_meta_r;
        end
    end

    assign link.wr_stb          = stb_r;
    assign link.cmd_data_select = a0_r;
    assign link.data            = data_r;
    assign link.hard_reset_n    = !hrst_r;
endmodule

// [test/lvip_asserts.sv]
module lvip_asserts (
    // Clock and reset.
    input wire logic       i_clk,
    input wire logic       i_rstn,
    // Link signals.
    input wire logic       wr_stb,
    input wire logic       cmd_data_select,
    input wire logic [7:0] data,
    input wire logic       hard_reset_n,
    input wire logic       display_blank_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import lvip_pkg::*;
    logic c_cmd;
    logic off_r;
    // A command byte is on the link.
    assign c_cmd = wr_stb && !cmd_data_select;
    // Tracks whether the display is switched off.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !hard_reset_n) begin
            off_r <= 1'b1;
        end else if (c_cmd && data == CMD_DISP_OFF) begin
            off_r <= 1'b1;
        end else if (c_cmd && data == CMD_DISP_ON) begin
            off_r <= 1'b0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_save_go;
        c_cmd && data == CMD_ALL_ON && off_r;
    endsequence
    sequence s_blank_hold;
        !display_blank_n [*2];
    endsequence
    property p_save_go;
        s_save_go |-> ##[1:2] !display_blank_n;
    endproperty
    property p_awake;
        c_cmd && data == CMD_ALL_ON && !off_r && display_blank_n
            |=> display_blank_n [*2];
    endproperty
    property p_save_end;
        c_cmd && data == CMD_ALL_NORM |-> ##[1:2] display_blank_n;
    endproperty
    property p_nop;
        c_cmd && data == CMD_NOP |=> $stable(display_blank_n) [*2];
    endproperty
    property p_ram_save;
        wr_stb && cmd_data_select && !display_blank_n |=> s_blank_hold;
    endproperty
    property p_rst_stby;
        c_cmd && data == CMD_RESET && !display_blank_n |=> s_blank_hold;
    endproperty
    property p_hard_rst;
        $fell(hard_reset_n) |-> ##[1:4] display_blank_n;
    endproperty
    property p_ind_pair;
        c_cmd && data == CMD_IND_ON |=> c_cmd;
    endproperty
    property p_ind_off;
        c_cmd && data == CMD_IND_OFF |=> !wr_stb;
    endproperty
    a_save_go: assert property (p_save_go)
        else $error("blank output not low after save entry");
    a_awake: assert property (p_awake)
        else $error("save entered with display on");
    a_save_end: assert property (p_save_end)
        else $error("blank output not high after save exit");
    a_nop: assert property (p_nop)
        else $error("no-operation byte changed blank output");
    a_ram_save: assert property (p_ram_save)
        else $error("memory write left power save");
    a_rst_stby: assert property (p_rst_stby)
        else $error("reset command left power save");
    a_hard_rst: assert property (p_hard_rst)
        else $error("hard reset did not clear power save");
    a_ind_pair: assert property (p_ind_pair)
        else $error("indicator on byte not followed by mode byte");
    a_ind_off: assert property (p_ind_off)
        else $error("indicator off byte followed by another byte");
endmodule

// [test/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lvip_pkg::*;
    logic i_clk, i_rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] lvl;
    logic osc, sup, duty, frm, seg, don, aon, slp, stby, ion, ramwr;
    logic [1:0] imode;
    logic [7:0] ramd;
    int n_errors = 0;
    int checks_done = 0;
    int n_ram = 0;
    lvip_if lnk();
    lvip_host lvip_host_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .link(lnk));
    lvip_dev #(.BLINK_SLOW_HALF(40), .BLINK_FAST_HALF(20)) lvip_dev_inst (
        .i_clk(i_clk), .i_rstn(i_rstn), .link(lnk), .o_lcd_drive_level(lvl),
        .o_osc_run(osc), .o_supply_run(sup), .o_duty_run(duty),
        .o_frame_polarity_out(frm), .o_indicator_segment_out(seg),
        .o_disp_on(don), .o_all_on(aon), .o_sleep(slp), .o_standby(stby),
        .o_ind_mode(imode), .o_ind_on(ion), .o_ram_wr(ramwr),
        .o_ram_wdata(ramd));
    lvip_asserts lvip_asserts_inst (.i_clk(i_clk), .i_rstn(i_rstn),
        .wr_stb(lnk.wr_stb), .cmd_data_select(lnk.cmd_data_select),
        .data(lnk.data), .hard_reset_n(lnk.hard_reset_n),
        .display_blank_n(lnk.display_blank_n));
    // Clock of 100 MHz.
    always #5 i_clk = ~i_clk;
    // Counts the display memory write pulses.
    always @(posedge i_clk) begin
        if (ramwr === 1'b1) begin
            n_ram <= n_ram + 1;
        end
    end
    // Prints the counts and the verdict, then stops.
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer is taken at the edge that sees pready high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) begin
            @(posedge i_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Writes a register, then waits until the link is quiet.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        r = 32'h1;
        while (r[STAT_BUSY_BIT] !== 1'b0) begin
            apb(1'b0, ADDR_STAT, 32'h0, r, e);
        end
        repeat (3) @(posedge i_clk);
    endtask
    // Sends one command byte.
    task automatic cmd(input logic [7:0] b);
        wr(ADDR_CMD, {24'h0, b});
    endtask
    // Volume pair, armed byte taken as value, no-operation.
    task automatic t_volume;
        logic [31:0] r;
        logic e;
        chk(lvl, VOL_RST);
        chk(osc, 1'b1);
        wr(ADDR_VOL, 32'h5);
        chk(lvl, 6'h05);
        apb(1'b0, ADDR_VOL, 32'h0, r, e);
        chk(r, 32'h5);
        wr(ADDR_VOL, 32'hffffffff);
        chk(lvl, 6'h3f);
        cmd(CMD_VOL_MODE);
        cmd(CMD_DISP_ON);
        chk(lvl, 6'h2f);
        chk(don, 1'b0);
        cmd(CMD_DISP_ON);
        chk(don, 1'b1);
        cmd(CMD_NOP);
        chk({lvl, don}, {6'h2f, 1'b1});
        $display("test volume done");
    endtask
    // Every indicator mode, the off byte, other commands.
    task automatic t_indicator;
        logic f;
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_IND, 32'h4 | m);
            chk({ion, imode}, {1'b1, m[1:0]});
            // Fast blink: the lit phase turns over once in 20 cycles.
            if (m == 2) begin
                @(negedge i_clk);
                f = seg ^ frm;
                repeat (20) @(negedge i_clk);
                chk(seg ^ frm, !f);
            end
        end
        wr(ADDR_IND, 32'h0);
        chk(ion, 1'b0);
        cmd(CMD_DISP_OFF);
        cmd(CMD_DISP_ON);
        chk(imode, IND_STEADY);
        wr(ADDR_IND, 32'h7);
        @(negedge i_clk);
        chk(seg, {31'h0, ~frm});
        r_frame_flip();
        wr(ADDR_IND, 32'h0);
        @(negedge i_clk);
        chk(seg, frm);
        $display("test indicator done");
    endtask
    // The frame output turns over every half period.
    task automatic r_frame_flip;
        logic f0;
        f0 = frm;
        repeat (FRAME_HALF_CYC) @(negedge i_clk);
        chk(frm, {31'h0, ~f0});
    endtask
    // Sleep, standby, reset command in standby, exit.
    task automatic t_power;
        cmd(CMD_ALL_ON);
        chk({aon, lnk.display_blank_n}, 2'b11);
        cmd(CMD_ALL_NORM);
        cmd(CMD_DISP_OFF);
        cmd(CMD_ALL_ON);
        chk({slp, stby, osc, sup}, 4'b1000);
        chk({lnk.display_blank_n, frm, seg}, 3'b011);
        wr(ADDR_CMD, {23'h0, 1'b1, 8'h5a});
        chk({ramd, slp}, {8'h5a, 1'b1});
        chk(n_ram, 1);
        cmd(CMD_ALL_NORM);
        chk({slp, osc, lnk.display_blank_n, don}, 4'b0110);
        wr(ADDR_IND, 32'h7);
        cmd(CMD_ALL_ON);
        chk({stby, slp, osc, sup, duty}, 5'b10100);
        @(negedge i_clk);
        chk(seg, {31'h0, ~frm});
        cmd(CMD_RESET);
        chk({slp, stby}, 2'b10);
        chk({lvl, ion}, {VOL_RST, 1'b0});
        cmd(CMD_ALL_NORM);
        chk(slp, 1'b0);
        $display("test power done");
    endtask
    // Unmapped address and the hard reset line.
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(r, 32'h0);
        chk(e, 1'b1);
        wr(ADDR_VOL, 32'h11);
        cmd(CMD_ALL_ON);
        apb(1'b0, ADDR_STAT, 32'h0, r, e);
        chk(r[STAT_BLANK_BIT], 1'b0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        chk({lvl, slp}, {VOL_RST, 1'b0});
        apb(1'b0, ADDR_STAT, 32'h0, r, e);
        chk(r[STAT_BLANK_BIT], 1'b1);
        $display("test registers done");
    endtask
    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        test_done();
    end
    // Main sequence.
    initial begin
        i_clk = 1'b0;
        i_rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_volume();
        t_indicator();
        t_power();
        t_regs();
        test_done();
    end
endmodule
